/* tpac_pkg.sv */
// Constants, register map and types shared by the teleprinter autostart control block
package tpac_pkg;

   // Clock rate and millisecond tick
   localparam int CLK_HZ       = 25_000_000;                 // System clock rate
   localparam int TICK_US      = 1000;                       // Tick period in microseconds
   localparam int TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US; // Cycles per tick
   localparam int TICK_W       = 16;                         // Tick divider width

   // Millisecond counters share one width
   localparam int MS_W         = 16;                         // Millisecond counter width

   // Durations in milliseconds
   localparam logic [MS_W-1:0] MOTOR_OFF_MS = 16'h4E20;     // 20 s without signal
   localparam logic [MS_W-1:0] RESP_FAST_MS = 16'h05DC;     // 1.5 s response
   localparam logic [MS_W-1:0] RESP_SLOW_MS = 16'h0DAC;     // 3.5 s response
   localparam logic [MS_W-1:0] ANTISPACE_MS = 16'h00FA;     // 250 ms space limit
   localparam logic [MS_W-1:0] QUAL_GAP_MS  = 16'h00C8;     // Longest gap between keying edges
   localparam logic [MS_W-1:0] KOS_HOLD_MS  = 16'h07D0;     // Transmit hang time

   // Avalon-MM register map, byte addresses
   localparam int AV_AW = 4;                                 // Byte address width
   localparam logic [AV_AW-1:0] CTRL_ADDR   = 4'h0;          // Control register
   localparam logic [AV_AW-1:0] STATUS_ADDR = 4'h4;          // Status register

   // Control register fields
   localparam int CTRL_SLOW_BIT = 0;                         // 1 = slow response
   localparam int CTRL_INV_BIT  = 1;                         // 1 = polarity_inverted
   localparam logic [1:0] CTRL_RESET = 2'h0;                 // Fast, polarity_normal

   // Status register fields
   localparam int STAT_VALID_BIT = 0;                        // Signal qualified
   localparam int STAT_MOTOR_BIT = 1;                        // Motor powered
   localparam int STAT_TX_BIT    = 2;                        // Transmit switch on
   localparam int STAT_AS_BIT    = 3;                        // Antispace forcing mark
   localparam int STAT_PRE_BIT   = 4;                        // Pre-qualification data
   localparam int STAT_POST_BIT  = 5;                        // Post-qualification data

   // Bus handshake states
   typedef enum logic {BUS_IDLE, BUS_ACK} tpac_bus_t;

endpackage : tpac_pkg

/* tpac_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module tpac_sync #(
   parameter logic RESET_VAL = 1'b0                          // Level held under reset
) (
   input  wire logic mclk,                                   // System clock
   input  wire logic rst,                                    // Async reset, active high
   input  wire logic pin,                                    // Asynchronous pin level
   output logic      level                                   // Clean level
);

   logic s1_r;                                               // First stage, metastable
   logic s2_r;                                               // Second stage
   logic s3_r;                                               // Third stage

   // Shift chain; only s2_r reads s1_r
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a new level only when the two settled stages agree
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         level <= RESET_VAL;
      else if (s2_r == s3_r)
         level <= s3_r;
   end

endmodule // tpac_sync

/* tpac_core.sv */
// Teleprinter autostart, antispace, keyboard switch and standby control
// Function
// [RL1] Unqualified signal holds printer output at mark
// [RL2] Motor off after twenty seconds without signal
// [RL3] Response time selectable: 1.5 or 3.5 s
// [RL4] Space longer than 250 ms returns to mark
// [RL5] Keyboard or Morse key turns transmit on
// [RL6] Transmit on puts demodulator in standby
// [RL7] Outside equipment may drive keyboard sense input
// [RL8] One polarity select inverts receive and keyer
// [RL9] Separate pre- and post-qualification data outputs
// [RL10] Valid only with sustained keying transitions
`timescale 1ns/10ps
module tpac_core
   import tpac_pkg::*;
#(
   parameter int TICK_CYC = tpac_pkg::TICK_CYCLES            // Cycles per ms tick
) (
   input  wire logic                          mclk,          // 25 MHz clock
   input  wire logic                          rst,           // Async reset, active high
   input  wire logic [tpac_pkg::AV_AW-1:0]    avs_address,   // Byte address
   input  wire logic                          avs_read,      // Read request
   input  wire logic                          avs_write,     // Write request
   input  wire logic [31:0]                   avs_writedata, // Write data
   input  wire logic [3:0]                    avs_byteenable,// Byte lanes
   output logic [31:0]                        avs_readdata,  // Read data
   output logic                               avs_waitrequest, // Stall
   input  wire logic                          slicer_mark,   // Slicer, 1 = mark tone
   input  wire logic                          keyboard_sense,// Keyboard keying activity
   input  wire logic                          morse_ident_key, // Morse key pressed
   input  wire logic                          keyer_data_in, // Tone keyer data in
   output logic                               pre_data,      // Data before autostart
   output logic                               post_data,     // Data after autostart
   output logic                               motor_on,      // Printer motor power
   output logic                               keyboard_transmit_switch, // Transmit on
   output logic                               keyer_data_out // Keyer data after polarity
);
   import tpac_pkg::*;

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1); // Divider wrap

   // Synchronised pins
   logic slicer_s;                                           // Slicer level
   logic kbd_s;                                              // Keyboard activity
   logic key_s;                                              // Morse key
   logic keyer_s;                                            // Keyer data

   // Control and internal state
   logic [1:0]        ctrl_r;                                // Control register
   logic [TICK_W-1:0] div_r;                                 // Tick divider
   logic              tick_r;                                // One-cycle ms pulse
   logic              rx_mark_r;                             // Polarity and standby applied
   logic              rx_prev_r;                             // Previous rx level
   logic [MS_W-1:0]   gap_ms_r;                              // Time since last edge
   logic [MS_W-1:0]   qual_ms_r;                             // Time of sustained keying
   logic              valid_r;                               // Signal qualified
   logic [MS_W-1:0]   idle_ms_r;                             // Time without valid signal
   logic [MS_W-1:0]   space_ms_r;                            // Current space length
   logic              as_data_r;                             // After antispace
   logic [MS_W-1:0]   kos_ms_r;                              // Time since key activity
   tpac_bus_t         bus_r;                                 // Bus handshake state
   logic [MS_W-1:0]   resp_ms;                               // Selected response time
   logic              inv;                                   // Polarity inverted
   logic              activity;                              // Key activity now

   // Decode of one mapped address
   function automatic logic hit(input logic [AV_AW-1:0] a, input logic [AV_AW-1:0] r);
      hit = (a == r);
   endfunction

   assign inv      = ctrl_r[CTRL_INV_BIT];
   assign resp_ms  = ctrl_r[CTRL_SLOW_BIT] ? RESP_SLOW_MS : RESP_FAST_MS; // [RL3]
   assign activity = kbd_s | key_s;

   // Pin synchronisers; idle slicer reads mark
   tpac_sync #(.RESET_VAL(1'b1)) u_sync_slicer
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (slicer_mark),
      .level (slicer_s)
   );
   // Sense input may be driven by outside equipment, so treated as a raw pin
   tpac_sync #(.RESET_VAL(1'b0)) u_sync_kbd                 // [RL7]
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (keyboard_sense),
      .level (kbd_s)
   );
   tpac_sync #(.RESET_VAL(1'b0)) u_sync_key
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (morse_ident_key),
      .level (key_s)
   );
   tpac_sync #(.RESET_VAL(1'b1)) u_sync_keyer
   (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (keyer_data_in),
      .level (keyer_s)
   );

   // Millisecond tick divider
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end
      else if (div_r == TICK_LAST)
      begin
         div_r  <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         div_r  <= div_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // Avalon-MM slave: one wait state, then a single cycle with waitrequest low
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         bus_r           <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= '0;
      end
      else
      begin
         case (bus_r)
            BUS_IDLE:
            begin
               if (avs_read || avs_write)
               begin
                  bus_r           <= BUS_ACK;
                  avs_waitrequest <= 1'b0;
                  // Unmapped addresses read as zero
                  avs_readdata    <= '0;
                  if (hit(avs_address, CTRL_ADDR))
                     avs_readdata[1:0] <= ctrl_r;
                  else if (hit(avs_address, STATUS_ADDR))
                     // Antispace flag: receive still in space, cut stage back at mark
                     avs_readdata[5:0] <= {post_data, pre_data, as_data_r & ~rx_mark_r,
                                           keyboard_transmit_switch, motor_on, valid_r};
               end
            end
            BUS_ACK:
            begin
               // Access completes at this edge; stall again
               bus_r           <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default:
            begin
               bus_r           <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Control register write, taken at the edge with waitrequest low
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ctrl_r <= CTRL_RESET;
      else if (avs_write && !avs_waitrequest && hit(avs_address, CTRL_ADDR)
               && avs_byteenable[0])
         ctrl_r <= avs_writedata[1:0];
   end

   // Receive data: polarity, then standby forces mark while transmitting
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rx_mark_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end
      else
      begin
         rx_mark_r <= keyboard_transmit_switch | (slicer_s ^ inv); // [RL6] [RL8]
         rx_prev_r <= rx_mark_r;
      end
   end

   // Keying edge gap; a steady tone or no signal saturates it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         gap_ms_r <= QUAL_GAP_MS;
      else if (rx_mark_r != rx_prev_r)
         gap_ms_r <= '0;                                     // [RL10]
      else if (tick_r && gap_ms_r < QUAL_GAP_MS)
         gap_ms_r <= gap_ms_r + 1'b1;
   end

   // Sustained keying time, restarted whenever keying stops
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         qual_ms_r <= '0;
      else if (gap_ms_r >= QUAL_GAP_MS)
         qual_ms_r <= '0;                                    // [RL10]
      else if (tick_r && qual_ms_r < RESP_SLOW_MS)
         qual_ms_r <= qual_ms_r + 1'b1;
   end

   // Qualification flag; switching speed mid-way applies at once
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         valid_r <= 1'b0;
      else if (gap_ms_r >= QUAL_GAP_MS)
         valid_r <= 1'b0;                                    // [RL10]
      else if (qual_ms_r >= resp_ms)
         valid_r <= 1'b1;                                    // [RL3]
   end

   // Time without a valid signal, saturating at the limit
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         idle_ms_r <= MOTOR_OFF_MS;
      else if (valid_r)
         idle_ms_r <= '0;
      else if (tick_r && idle_ms_r < MOTOR_OFF_MS)
         idle_ms_r <= idle_ms_r + 1'b1;
   end

   // Motor power: on with a valid signal, off after the idle limit
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         motor_on <= 1'b0;
      else if (valid_r)
         motor_on <= 1'b1;
      else if (idle_ms_r >= MOTOR_OFF_MS)
         motor_on <= 1'b0;                                   // [RL2]
   end

   // Space length; held at the limit until mark returns
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         space_ms_r <= '0;
      else if (rx_mark_r)
         space_ms_r <= '0;
      else if (tick_r && space_ms_r < ANTISPACE_MS)
         space_ms_r <= space_ms_r + 1'b1;
   end

   // Antispace: long space is cut back to mark
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         as_data_r <= 1'b1;
      else
         as_data_r <= rx_mark_r | (space_ms_r >= ANTISPACE_MS); // [RL4]
   end

   // Data outputs before and after qualification
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pre_data  <= 1'b1;
         post_data <= 1'b1;
      end
      else
      begin
         pre_data  <= as_data_r;                             // [RL9]
         post_data <= valid_r ? as_data_r : 1'b1;            // [RL1] [RL9]
      end
   end

   // Transmit hang timer restarts on every key activity
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         kos_ms_r <= KOS_HOLD_MS;
      else if (activity)
         kos_ms_r <= '0;
      else if (tick_r && kos_ms_r < KOS_HOLD_MS)
         kos_ms_r <= kos_ms_r + 1'b1;
   end

   // Transmit switch; hang time keeps it from chattering between characters
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         keyboard_transmit_switch <= 1'b0;
      else
         keyboard_transmit_switch <= activity | (kos_ms_r < KOS_HOLD_MS); // [RL5]
   end

   // Keyer data follows the same polarity select
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         keyer_data_out <= 1'b1;
      else
         keyer_data_out <= keyer_s ^ inv;                    // [RL8]
   end

   // Checks
   a_hold_mark: assert property (@(posedge mclk) disable iff (rst) // [RL1]
      !valid_r |=> post_data)
      else $error("post data not held at mark without valid signal");

   a_motor_off: assert property (@(posedge mclk) disable iff (rst) // [RL2]
      (!valid_r && idle_ms_r >= MOTOR_OFF_MS) |=> !motor_on)
      else $error("motor still on after idle limit");

   a_qual_time: assert property (@(posedge mclk) disable iff (rst) // [RL3]
      $rose(valid_r) |-> $past(qual_ms_r) >= $past(resp_ms))
      else $error("signal qualified before response time");

   a_space_limit: assert property (@(posedge mclk) disable iff (rst) // [RL4]
      (space_ms_r >= ANTISPACE_MS) |=> as_data_r ##1 pre_data)
      else $error("space not cut back to mark");

   a_tx_on_key: assert property (@(posedge mclk) disable iff (rst) // [RL5]
      activity |=> keyboard_transmit_switch)
      else $error("transmit switch not on with key activity");

   a_standby_mark: assert property (@(posedge mclk) disable iff (rst) // [RL6]
      keyboard_transmit_switch |=> rx_mark_r)
      else $error("receive path not in standby while transmitting");

   a_keyer_polarity: assert property (@(posedge mclk) disable iff (rst) // [RL8]
      !$past(rst) |-> keyer_data_out == ($past(keyer_s) ^ $past(inv)))
      else $error("keyer polarity wrong");

   a_pre_output: assert property (@(posedge mclk) disable iff (rst) // [RL9]
      !$past(rst) |-> pre_data == $past(as_data_r))
      else $error("pre data does not follow antispace stage");

   a_steady_invalid: assert property (@(posedge mclk) disable iff (rst) // [RL10]
      (gap_ms_r >= QUAL_GAP_MS) |=> !valid_r)
      else $error("valid without keying transitions");

endmodule // tpac_core

/* tpac_far_model.sv */
// Far-side model: printer loop, motor supply and teleprinter keyboard
`timescale 1ns/10ps
module tpac_far_model (
   input  wire logic       mclk,           // System clock
   input  wire logic       rst,            // Async reset, active high
   input  wire logic       post_data,      // Loop keying, 1 = mark
   input  wire logic       motor_on,       // Motor supply relay
   input  wire logic       tx_switch,      // Transmitter keyed
   input  wire logic       type_key,       // Bench asks the keyboard to type
   output logic            keyboard_sense, // Keyboard activity line
   output logic [15:0]     garbled         // Loop changes with motor unpowered, or space while keyed
);
   logic       post_prev_r;                // Last loop level
   logic [3:0] tx_hist_r;                  // Recent transmitter states

   // Keyboard drives the sense line straight, changing just after an edge
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         keyboard_sense <= 1'b0;
      else
         keyboard_sense <= type_key;
   end

   // A stopped printer must see a steady mark, or it would run open
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         post_prev_r <= 1'b1;
         tx_hist_r   <= 4'h0;
         garbled     <= 16'h0000;
      end
      else
      begin
         post_prev_r <= post_data;
         tx_hist_r   <= {tx_hist_r[2:0], tx_switch};
         // Motor off means no qualified signal, so the loop may not move
         if (!motor_on && post_data !== post_prev_r)
            garbled <= garbled + 16'h0001;
         // Keyed transmitter must not hear space; four cycles cover the output pipeline
         else if (&tx_hist_r && !post_data && post_prev_r)
            garbled <= garbled + 16'h0001;
      end
   end
endmodule // tpac_far_model

/* testbench.sv */
// Self-checking bench for the teleprinter autostart control block
`timescale 1ns/10ps
module testbench;
   import tpac_pkg::*;
   localparam int TCYC = 2;               // Cycles per tick, shortened for run time
   logic        mclk, rst;                // Clock and reset
   logic [3:0]  avs_address;              // Bus address
   logic        avs_read, avs_write;      // Bus strobes
   logic [31:0] avs_writedata;            // Bus write data
   logic [3:0]  avs_byteenable;           // Bus lanes
   logic [31:0] avs_readdata;             // Bus read data
   logic        avs_waitrequest;          // Bus stall
   logic        slicer_mark, slicer_lvl;  // Slicer pin and its steady level
   logic        keying;                   // Toggle slicer like teleprinter traffic
   logic [7:0]  kcnt;                     // Keying half-period counter
   logic        keyboard_sense, morse_ident_key, keyer_data_in, type_key;
   logic        pre_data, post_data, motor_on, keyboard_transmit_switch, keyer_data_out;
   logic [15:0] garbled;                  // Far-side complaint count
   logic [31:0] rd;                       // Read-back word
   int          fail_count, checks;       // Mismatches and comparisons

   tpac_core #(.TICK_CYC(TCYC)) i_dut (
      .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .slicer_mark(slicer_mark),
      .keyboard_sense(keyboard_sense), .morse_ident_key(morse_ident_key),
      .keyer_data_in(keyer_data_in), .pre_data(pre_data), .post_data(post_data),
      .motor_on(motor_on), .keyboard_transmit_switch(keyboard_transmit_switch),
      .keyer_data_out(keyer_data_out));

   tpac_far_model i_far (
      .mclk(mclk), .rst(rst), .post_data(post_data), .motor_on(motor_on),
      .tx_switch(keyboard_transmit_switch), .type_key(type_key),
      .keyboard_sense(keyboard_sense), .garbled(garbled));

   // 25 MHz clock
   always #20 mclk = ~mclk;

   // Slicer source; 100-cycle half period keeps edges well inside the gap limit
   always @(posedge mclk)
   begin
      kcnt <= (kcnt == 8'h63) ? 8'h00 : kcnt + 8'h01;
      if (keying && kcnt == 8'h63)
         slicer_mark <= ~slicer_mark;
      else if (!keying)
         slicer_mark <= slicer_lvl;
   end

   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Bus read: hold the request until waitrequest is seen low
   task bus_rd(input logic [3:0] a, output logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_read    <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         chk(1, 0, "read hang");
         final_report;
      end
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask

   // Bus write, same handshake
   task bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         chk(1, 0, "write hang");
         final_report;
      end
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   // Wait a number of ms ticks
   task ticks(input int n);
      repeat (n * TCYC) @(posedge mclk);
   endtask

   // Verdict, shared by the tests and the watchdog
   task final_report;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog, about a quarter above the expected run
   initial
   begin
      repeat (65000) @(posedge mclk);
      fail_count++;
      final_report;
   end

   // Test sequence
   initial
   begin
      mclk = 0; rst = 1; avs_address = 0; avs_read = 0; avs_write = 0;
      avs_writedata = 0; avs_byteenable = 4'hF; slicer_mark = 1; slicer_lvl = 1;
      keying = 0; kcnt = 0; morse_ident_key = 0; keyer_data_in = 1; type_key = 0;
      fail_count = 0; checks = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (10) @(posedge mclk);
      // Reset state and bus refusals
      chk(motor_on, 0, "motor at reset");
      chk(post_data, 1, "post at reset");
      chk(keyboard_transmit_switch, 0, "tx at reset");
      chk(keyer_data_out, 1, "keyer normal");
      bus_wr(CTRL_ADDR, 32'h0000_0003, 4'h0);
      bus_rd(CTRL_ADDR, rd);
      chk(rd, 0, "ctrl lane off");
      bus_wr(4'h8, 32'hFFFF_FFFF, 4'hF);
      bus_rd(4'h8, rd);
      chk(rd, 0, "unmapped");
      $display("test reset done");
      // Steady space: mark-hold after, space before, then antispace
      slicer_lvl <= 1'b0;
      repeat (20) @(posedge mclk);
      chk(pre_data, 0, "pre space");
      chk(post_data, 1, "post held mark");
      ticks(225);
      chk(pre_data, 0, "space under limit");
      ticks(35);
      chk(pre_data, 1, "space cut to mark");
      bus_rd(STATUS_ADDR, rd);
      chk(rd[STAT_AS_BIT], 1, "antispace flag");
      chk(rd[STAT_VALID_BIT], 0, "steady not valid");
      slicer_lvl <= 1'b1;
      $display("test antispace done");
      // Fast response
      keying <= 1'b1;
      ticks(1400);
      chk(motor_on, 0, "fast too early");
      ticks(200);
      chk(motor_on, 1, "fast qualified");
      // Mid half-period the whole pipeline has settled on the slicer level
      repeat (3)
      begin
         wait (kcnt == 8'h32);
         chk(post_data, slicer_mark, "post follows line");
         @(posedge mclk);
      end
      $display("test fast done");
      // Loss of signal, transmit switching, motor time-out
      keying <= 1'b0;
      slicer_lvl <= 1'b1;
      morse_ident_key <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(keyboard_transmit_switch, 1, "morse key tx");
      slicer_lvl <= 1'b0;
      repeat (50) @(posedge mclk);
      chk(pre_data, 1, "standby mark");
      morse_ident_key <= 1'b0;
      slicer_lvl <= 1'b1;
      ticks(2100);
      chk(keyboard_transmit_switch, 0, "tx hang over");
      bus_rd(STATUS_ADDR, rd);
      chk(rd[STAT_VALID_BIT], 0, "valid dropped");
      type_key <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(keyboard_transmit_switch, 1, "keyboard tx");
      type_key <= 1'b0;
      ticks(17900);
      chk(motor_on, 1, "motor still on");
      ticks(300);
      chk(motor_on, 0, "motor off");
      chk(post_data, 1, "post mark no signal");
      $display("test motor done");
      // Slow response
      bus_wr(CTRL_ADDR, 32'h0000_0001, 4'h1);
      bus_rd(CTRL_ADDR, rd);
      chk(rd, 1, "ctrl slow");
      keying <= 1'b1;
      ticks(3400);
      bus_rd(STATUS_ADDR, rd);
      chk(rd[STAT_VALID_BIT], 0, "slow too early");
      ticks(200);
      bus_rd(STATUS_ADDR, rd);
      chk(rd[STAT_VALID_BIT], 1, "slow qualified");
      chk(motor_on, 1, "motor back on");
      $display("test slow done");
      // Polarity on receive and keyer together
      keying <= 1'b0;
      for (int p = 1; p >= 0; p--)
      begin
         bus_wr(CTRL_ADDR, {30'h0, p[0], 1'b1}, 4'h1);
         for (int k = 0; k < 2; k++)
         begin
            keyer_data_in <= k[0];
            repeat (20) @(posedge mclk);
            chk(keyer_data_out, k[0] ^ p[0], "keyer sense");
            chk(pre_data, !p[0], "receive sense");
         end
      end
      chk(garbled, 0, "printer ran unpowered");
      $display("test polarity done");
      final_report;
   end
endmodule // testbench
